// ### src/mrd_pkg.sv
// Package: register map, field layout, reset values and map constants
package mrd_pkg;
    localparam logic [15:0] OFF_MODE = 16'h000b;
    localparam logic [15:0] OFF_REGPOS = 16'h0011;
    localparam logic [15:0] OFF_RAMPOS = 16'h0010;
    localparam logic [15:0] OFF_EEPOS = 16'h0012;
    localparam logic [15:0] OFF_MISC = 16'h0013;
    localparam logic [15:0] OFF_PORT_E_DATA = 16'h0008;
    localparam logic [15:0] OFF_PORT_E_DIRECTION = 16'h0009;
    localparam int B_SPECIAL_MODE_LOW = 7;
    localparam int B_MODE_SELECT_B = 6;
    localparam int B_MODE_SELECT_A = 5;
    localparam int B_E_CLOCK_STRETCH_EN = 4;
    localparam int B_INTERNAL_VISIBILITY = 3;
    localparam int B_EBSW = 2;
    localparam int B_EME = 0;
    localparam int B_MMSW = 0;
    localparam int B_SWAP = 7;
    localparam logic [15:0] DBG_REG_LO = 16'hff00;
    localparam logic [15:0] DBG_REG_HI = 16'hff06;
    localparam logic [15:0] DBG_ROM_LO = 16'hff20;
    localparam logic [15:0] DBG_ROM_HI = 16'hffff;
    localparam logic [15:0] FSM_LO = 16'h1000;
    localparam logic [15:0] FSM_HI = 16'h7fff;
    localparam logic [15:0] FSM_SW_LO = 16'h9000;
    localparam logic [15:0] FLG_LO = 16'h8000;
    localparam logic [7:0] EEPOS_RST = 8'h01;
    localparam int WAIT_DELAY_NS = 40;
    localparam int CLK_NS = 10;
    localparam logic [3:0] WAIT_CYC = 4'((WAIT_DELAY_NS + CLK_NS - 1) / CLK_NS);
    typedef enum logic [2:0] {
        SEL_NONE, SEL_DBGROM, SEL_DBGREG, SEL_REG, SEL_RAM, SEL_EE,
        SEL_FLASH, SEL_EXT
    } mrd_sel_type;
    typedef struct packed {
        logic [15:0] addr;
        logic serial;
    } mrd_acc_type;
endpackage

// ### src/mrd_decode.sv
// Address decoder: fixed precedence selection of mapped resources
`timescale 1ns/100ps
module mrd_decode (
    input wire mrd_pkg::mrd_acc_type acc,
    input wire logic dbg_active,
    input wire logic expanded,
    input wire logic single_chip,
    input wire logic port_e_emulate,
    input wire logic swap,
    input wire logic [4:0] reg_pos,
    input wire logic [4:0] ram_pos,
    input wire logic [3:0] ee_pos,
    input wire logic ee_on,
    output mrd_pkg::mrd_sel_type sel,
    output logic port_e_data_hidden
);
    logic in_reg;
    logic in_ram;
    logic in_ee;
    logic in_fl;
    logic top_page;
    always_comb begin
        in_reg = acc.addr[15:11] == reg_pos && acc.addr[10:9] == 2'b00;
        in_ram = acc.addr[15:11] == ram_pos;
        in_ee = ee_on && acc.addr[15:12] == ee_pos
            && acc.addr[11:10] == 2'b11;
        if (swap) begin
            in_fl = acc.addr < mrd_pkg::FSM_HI + 16'h0001
                || acc.addr >= mrd_pkg::FSM_SW_LO; // RULE_20
        end else begin
            in_fl = acc.addr >= mrd_pkg::FSM_LO; // RULE_20
        end
        top_page = acc.addr[15:8] == 8'hff;
        // Port E pair drops out only when emulated externally
        port_e_data_hidden = port_e_emulate && expanded && !single_chip; // RULE_15
        sel = mrd_pkg::SEL_NONE;
        if (dbg_active && acc.addr >= mrd_pkg::DBG_ROM_LO) begin
            sel = mrd_pkg::SEL_DBGROM; // RULE_01
        end else if (dbg_active && acc.addr >= mrd_pkg::DBG_REG_LO
                && acc.addr <= mrd_pkg::DBG_REG_HI) begin
            sel = mrd_pkg::SEL_DBGREG; // RULE_02
        end else if (dbg_active && top_page && !acc.serial) begin
            sel = mrd_pkg::SEL_NONE; // RULE_03
        end else if (in_reg) begin
            sel = mrd_pkg::SEL_REG; // RULE_18
        end else if (in_ram) begin
            sel = mrd_pkg::SEL_RAM;
        end else if (in_ee) begin
            sel = mrd_pkg::SEL_EE;
        end else if (in_fl) begin
            sel = mrd_pkg::SEL_FLASH;
        end else if (expanded) begin
            sel = mrd_pkg::SEL_EXT; // RULE_19
        end
    end
endmodule

// ### src/mrd_top.sv
// Mode control register, map registers and resource decoder top
// Behaviour
// RULE_01: Active debug maps ROM FF20-FFFF over vectors
// RULE_02: Active debug maps control registers FF00-FF06
// RULE_03: Active debug hides top page except serial
// RULE_04: Special single-chip starts debug active
// RULE_05: Enabled debug activates by command or instruction
// RULE_06: Mode bits latch pins at reset release
// RULE_07: Special bit written only special, first ignored
// RULE_08: Mode B/A once normal, never special peripheral
// RULE_09: Mode register unmapped in special peripheral
// RULE_10: Clock stretch reads one when expanded
// RULE_11: E clock free or stretched per enable
// RULE_12: Visibility drives internal bus, not single-chip
// RULE_13: Visibility and emulation once normal, special skip-first
// RULE_14: Bus wait-stop delays then shuts in wait
// RULE_15: Port E unmapped when emulated and expanded
// RULE_16: Position registers write once in normal
// RULE_17: Map writes take effect next cycle
// RULE_18: Fixed precedence debug, regs, RAM, EEPROM, flash
// RULE_19: Unclaimed expanded addresses go external
// RULE_20: Flash arrays at reset places, swappable
// RULE_21: Register block 512 bytes at 2K boundary
// RULE_22: Map wait-stop shuts mapping in wait
// RULE_23: Normal protects controls, special opens them
// RULE_24: Reset values for visibility, emulation, stretch
`timescale 1ns/100ps
module mrd_top (
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    input wire logic [15:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic BACKGROUND_PIN_PIN,
    input wire logic MODE_SELECT_B_PIN,
    input wire logic MODE_SELECT_A_PIN,
    input wire logic DBG_ENABLE,
    input wire logic DBG_SERIAL_ACT,
    input wire logic DBG_INSTR,
    input wire logic DBG_EXIT,
    input wire logic [15:0] CPU_ADDR,
    input wire logic CPU_SERIAL,
    input wire logic CPU_EXT_CYCLE,
    input wire logic WAIT_MODE,
    input wire logic E_PHASE,
    output mrd_pkg::mrd_sel_type SEL,
    output logic PORT_E_DATA_HIDDEN,
    output logic DBG_ACTIVE,
    output logic E_CLK,
    output logic VIS_EN,
    output logic VIS_WIDE,
    output logic EXT_BUS_OFF,
    output logic MAP_OFF
);
    logic [1:0] bk_s, mb_s, ma_s;
    logic rst_d1_q;
    logic special_mode_low_q, special_mode_low_d, mode_select_b_q, mode_select_b_d, mode_select_a_q, mode_select_a_d;
    logic e_clock_stretch_en_q, e_clock_stretch_en_d, internal_visibility_q, internal_visibility_d, ebsw_q, ebsw_d, eme_q, eme_d;
    logic mmsw_q, mmsw_d, swap_q, swap_d;
    logic [4:0] rpos_q, rpos_d, mpos_q, mpos_d;
    logic [7:0] epos_q, epos_d;
    logic mode_wr_q, mode_wr_d, rp_wr_q, rp_wr_d, mp_wr_q, mp_wr_d;
    logic ep_wr_q, ep_wr_d, misc_wr_q, misc_wr_d;
    logic dbg_q, dbg_d;
    logic [3:0] wcnt_q, wcnt_d;
    logic [7:0] rdata_d;
    logic special, single_chip, expanded, periph, w_mode, w_ok, first;
    logic [1:0] new_ba;
    mrd_pkg::mrd_acc_type acc;

    // Pins cross in through two stages before use
    always_ff @(posedge CLK_SYS) begin
        bk_s <= {bk_s[0], BACKGROUND_PIN_PIN};
        mb_s <= {mb_s[0], MODE_SELECT_B_PIN};
        ma_s <= {ma_s[0], MODE_SELECT_A_PIN};
        rst_d1_q <= SYS_RST;
    end

    always_comb begin
        special = !special_mode_low_q;
        single_chip = !mode_select_b_q && !mode_select_a_q;
        periph = special && mode_select_b_q && !mode_select_a_q;
        expanded = !single_chip && !periph;
        w_mode = WR && ADDR == mrd_pkg::OFF_MODE && !periph; // RULE_09
        first = !mode_wr_q;
        w_ok = special ? !first : first;
        new_ba = WDATA[mrd_pkg::B_MODE_SELECT_B:mrd_pkg::B_MODE_SELECT_A];
    end

    always_comb begin
        special_mode_low_d = special_mode_low_q;
        mode_select_b_d = mode_select_b_q;
        mode_select_a_d = mode_select_a_q;
        e_clock_stretch_en_d = e_clock_stretch_en_q;
        internal_visibility_d = internal_visibility_q;
        ebsw_d = ebsw_q;
        eme_d = eme_q;
        mode_wr_d = mode_wr_q;
        if (rst_d1_q) begin
            // Caught from synchronised pins at reset release
            special_mode_low_d = bk_s[1]; // RULE_06
            mode_select_b_d = mb_s[1];
            mode_select_a_d = ma_s[1];
            if (mb_s[1] && !ma_s[1]) begin
                special_mode_low_d = 1'b0; // Reserved forced to peripheral
            end
            e_clock_stretch_en_d = 1'b1; // RULE_24
            // Reserved straps land in peripheral, a special mode
            internal_visibility_d = !bk_s[1] || (mb_s[1] && !ma_s[1]);
            eme_d = !bk_s[1] || (mb_s[1] && !ma_s[1]);
            ebsw_d = 1'b0;
        end else if (w_mode) begin
            mode_wr_d = 1'b1;
            if (special && !first) begin // RULE_07
                special_mode_low_d = WDATA[mrd_pkg::B_SPECIAL_MODE_LOW];
            end
            if (w_ok && new_ba != 2'b10) begin // RULE_08
                mode_select_b_d = WDATA[mrd_pkg::B_MODE_SELECT_B];
                mode_select_a_d = WDATA[mrd_pkg::B_MODE_SELECT_A];
            end
            if (special || first) begin // RULE_11
                e_clock_stretch_en_d = WDATA[mrd_pkg::B_E_CLOCK_STRETCH_EN];
            end
            if (w_ok) begin // RULE_13
                internal_visibility_d = WDATA[mrd_pkg::B_INTERNAL_VISIBILITY];
                eme_d = WDATA[mrd_pkg::B_EME];
            end
            if (!special) begin // RULE_14
                ebsw_d = WDATA[mrd_pkg::B_EBSW];
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            special_mode_low_q <= 1'b1;
            mode_select_b_q <= 1'b0;
            mode_select_a_q <= 1'b0;
            e_clock_stretch_en_q <= 1'b1;
            internal_visibility_q <= 1'b0;
            ebsw_q <= 1'b0;
            eme_q <= 1'b0;
            mode_wr_q <= 1'b0;
        end else begin
            special_mode_low_q <= special_mode_low_d;
            mode_select_b_q <= mode_select_b_d;
            mode_select_a_q <= mode_select_a_d;
            e_clock_stretch_en_q <= e_clock_stretch_en_d;
            internal_visibility_q <= internal_visibility_d;
            ebsw_q <= ebsw_d;
            eme_q <= eme_d;
            mode_wr_q <= mode_wr_d;
        end
    end

    // Positions and swap: once in normal, any time special; mmsw any time in normal only, EE enable bit any time
    always_comb begin
        rpos_d = rpos_q;
        mpos_d = mpos_q;
        epos_d = epos_q;
        swap_d = swap_q;
        mmsw_d = mmsw_q;
        rp_wr_d = rp_wr_q;
        mp_wr_d = mp_wr_q;
        ep_wr_d = ep_wr_q;
        misc_wr_d = misc_wr_q;
        if (WR && ADDR == mrd_pkg::OFF_REGPOS) begin
            rp_wr_d = 1'b1;
            if (special || !rp_wr_q) begin // RULE_16 RULE_21 RULE_23
                rpos_d = WDATA[7:3];
            end
            if (!special) begin // RULE_22
                mmsw_d = WDATA[mrd_pkg::B_MMSW];
            end
        end
        if (WR && ADDR == mrd_pkg::OFF_RAMPOS) begin
            mp_wr_d = 1'b1;
            if (special || !mp_wr_q) begin // RULE_16
                mpos_d = WDATA[7:3];
            end
        end
        if (WR && ADDR == mrd_pkg::OFF_EEPOS) begin
            ep_wr_d = 1'b1;
            if (special || !ep_wr_q) begin // RULE_16
                epos_d[7:4] = WDATA[7:4];
            end
            epos_d[0] = WDATA[0] || single_chip;
        end
        if (WR && ADDR == mrd_pkg::OFF_MISC) begin
            misc_wr_d = 1'b1;
            if (special || !misc_wr_q) begin
                swap_d = WDATA[mrd_pkg::B_SWAP]; // RULE_20
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            rpos_q <= 5'h00; // RULE_21
            mpos_q <= 5'h00;
            epos_q <= mrd_pkg::EEPOS_RST;
            swap_q <= 1'b0;
            mmsw_q <= 1'b0;
            rp_wr_q <= 1'b0;
            mp_wr_q <= 1'b0;
            ep_wr_q <= 1'b0;
            misc_wr_q <= 1'b0;
        end else begin
            rpos_q <= rpos_d;
            mpos_q <= mpos_d;
            epos_q <= epos_d;
            swap_q <= swap_d;
            mmsw_q <= mmsw_d;
            rp_wr_q <= rp_wr_d;
            mp_wr_q <= mp_wr_d;
            ep_wr_q <= ep_wr_d;
            misc_wr_q <= misc_wr_d;
        end
    end

    // Debug activation and wait-mode shutdown delay
    always_comb begin
        dbg_d = dbg_q;
        if (rst_d1_q) begin
            dbg_d = !bk_s[1] && !mb_s[1] && !ma_s[1]; // RULE_04
        end else if (DBG_EXIT) begin
            dbg_d = 1'b0;
        end else if (DBG_ENABLE && (DBG_SERIAL_ACT || DBG_INSTR)) begin
            dbg_d = 1'b1; // RULE_05
        end
        wcnt_d = 4'h0;
        if (WAIT_MODE && ebsw_q) begin // RULE_14
            wcnt_d = wcnt_q == mrd_pkg::WAIT_CYC ? wcnt_q : wcnt_q + 4'h1;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            dbg_q <= 1'b0;
            wcnt_q <= 4'h0;
        end else begin
            dbg_q <= dbg_d;
            wcnt_q <= wcnt_d;
        end
    end

    // Register read port, data valid one cycle after strobe
    always_comb begin
        rdata_d = 8'h00;
        if (RD && ADDR == mrd_pkg::OFF_MODE && !periph) begin
            rdata_d = {special_mode_low_q, mode_select_b_q, mode_select_a_q, e_clock_stretch_en_q || expanded,
                internal_visibility_q, ebsw_q, 1'b0, eme_q}; // RULE_10
        end else if (RD && ADDR == mrd_pkg::OFF_REGPOS) begin
            rdata_d = {rpos_q, 2'b00, mmsw_q};
        end else if (RD && ADDR == mrd_pkg::OFF_RAMPOS) begin
            rdata_d = {mpos_q, 3'h0};
        end else if (RD && ADDR == mrd_pkg::OFF_EEPOS) begin
            rdata_d = epos_q;
        end else if (RD && ADDR == mrd_pkg::OFF_MISC) begin
            rdata_d = {swap_q, 7'h00};
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            RDATA <= 8'h00;
        end else begin
            RDATA <= rdata_d;
        end
    end

    // Decode uses registered map state, so a write lands next cycle
    always_comb begin
        acc.addr = CPU_ADDR;
        acc.serial = CPU_SERIAL;
    end

    mrd_decode u_dec (
        .acc(acc),
        .dbg_active(dbg_q), // RULE_17
        .expanded(expanded),
        .single_chip(single_chip),
        .port_e_emulate(eme_q),
        .swap(swap_q),
        .reg_pos(rpos_q),
        .ram_pos(mpos_q),
        .ee_pos(epos_q[7:4]),
        .ee_on(epos_q[0]),
        .sel(SEL),
        .port_e_data_hidden(PORT_E_DATA_HIDDEN)
    );

    always_comb begin
        DBG_ACTIVE = dbg_q;
        VIS_EN = internal_visibility_q && !single_chip; // RULE_12
        VIS_WIDE = VIS_EN && special && !mode_select_b_q && mode_select_a_q;
        // Stretched: high on external cycles, low on hidden internal
        if (e_clock_stretch_en_q || expanded) begin // RULE_11
            E_CLK = CPU_EXT_CYCLE ? 1'b1 : (internal_visibility_q ? E_PHASE : 1'b0);
        end else begin
            E_CLK = E_PHASE;
        end
        EXT_BUS_OFF = wcnt_q == mrd_pkg::WAIT_CYC; // RULE_14
        MAP_OFF = WAIT_MODE && mmsw_q; // RULE_22
    end

    chk_bus_off_delay: assert property ( // RULE_14
        @(posedge CLK_SYS) disable iff (SYS_RST)
        $rose(EXT_BUS_OFF) |-> $past(WAIT_MODE, 4) && $past(WAIT_MODE, 1))
        else $error("bus shut down before delay");
    chk_vis_single: assert property ( // RULE_12
        @(posedge CLK_SYS) disable iff (SYS_RST)
        single_chip |-> !VIS_EN)
        else $error("visibility in single chip");
    chk_dbg_rom: assert property ( // RULE_01
        @(posedge CLK_SYS) disable iff (SYS_RST)
        dbg_q && CPU_ADDR >= mrd_pkg::DBG_ROM_LO
        |-> SEL == mrd_pkg::SEL_DBGROM)
        else $error("debug rom not selected");
    chk_top_hidden: assert property ( // RULE_03
        @(posedge CLK_SYS) disable iff (SYS_RST)
        dbg_q && CPU_ADDR[15:8] == 8'hff && !CPU_SERIAL
        |-> SEL inside {mrd_pkg::SEL_DBGROM, mrd_pkg::SEL_DBGREG,
        mrd_pkg::SEL_NONE})
        else $error("user top page reached");
    chk_no_periph: assert property ( // RULE_08
        @(posedge CLK_SYS) disable iff (SYS_RST || rst_d1_q)
        !special |-> !(mode_select_b_q && !mode_select_a_q))
        else $error("reserved mode selected");
    chk_map_delay: assert property ( // RULE_17
        @(posedge CLK_SYS) disable iff (SYS_RST)
        WR && ADDR == mrd_pkg::OFF_REGPOS && !special
        && !rp_wr_q |=> rpos_q == $past(WDATA[7:3]))
        else $error("map write not applied");
    chk_once_normal: assert property ( // RULE_16
        @(posedge CLK_SYS) disable iff (SYS_RST)
        !special && rp_wr_q |=> $stable(rpos_q))
        else $error("position rewritten in normal");
    chk_stretch_exp: assert property ( // RULE_10
        @(posedge CLK_SYS) disable iff (SYS_RST)
        RD && ADDR == mrd_pkg::OFF_MODE && expanded
        && !periph |=> RDATA[mrd_pkg::B_E_CLOCK_STRETCH_EN])
        else $error("stretch bit read zero");
endmodule

// ### bench/mrd_far_model.sv
// Far-side model: CPU address source, free E phase, external cycle flag
`timescale 1ns/100ps
module mrd_far_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] req_addr,
    input wire logic req_serial,
    input wire mrd_pkg::mrd_sel_type sel,
    output logic [15:0] cpu_addr,
    output logic cpu_serial,
    output logic ext_cycle,
    output logic e_phase
);
    // CPU holds address and access kind for the whole cycle
    assign cpu_addr = req_addr;
    assign cpu_serial = req_serial;
    // External flag registered, avoids a loop through the decode
    always_ff @(posedge clk) begin
        if (rst) begin
            e_phase <= 1'b0;
            ext_cycle <= 1'b0;
        end else begin
            e_phase <= ~e_phase;
            ext_cycle <= (sel == mrd_pkg::SEL_EXT);
        end
    end
endmodule

// ### bench/test_mode_and_resource_map_decoder.sv
// Testbench: mode register, map registers and decode checks
`timescale 1ns/100ps
module test_mode_and_resource_map_decoder;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [2:0] straps = 3'h4;
    logic dbg_en = 1'b0;
    logic [2:0] pv = 3'h0;
    logic wait_mode = 1'b0;
    logic [15:0] req_addr = 16'h0000;
    logic req_serial = 1'b0;
    logic [7:0] rdata;
    mrd_pkg::mrd_sel_type sel;
    logic port_e_data_hid, dbg_act, e_clk, vis_en, vis_wide, ext_off, map_off;
    logic [15:0] cpu_addr;
    logic cpu_serial, ext_cycle, e_phase;
    int err_total = 0;
    int check_count = 0;

    always #5 clk = ~clk;

    mrd_top u_mrd_top (.CLK_SYS(clk), .SYS_RST(rst), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .BACKGROUND_PIN_PIN(straps[2]), .MODE_SELECT_B_PIN(straps[1]), .MODE_SELECT_A_PIN(straps[0]),
        .DBG_ENABLE(dbg_en), .DBG_SERIAL_ACT(pv[0]), .DBG_INSTR(pv[1]),
        .DBG_EXIT(pv[2]), .CPU_ADDR(cpu_addr), .CPU_SERIAL(cpu_serial),
        .CPU_EXT_CYCLE(ext_cycle), .WAIT_MODE(wait_mode),
        .E_PHASE(e_phase), .SEL(sel), .PORT_E_DATA_HIDDEN(port_e_data_hid),
        .DBG_ACTIVE(dbg_act), .E_CLK(e_clk), .VIS_EN(vis_en),
        .VIS_WIDE(vis_wide), .EXT_BUS_OFF(ext_off), .MAP_OFF(map_off));

    mrd_far_model u_mrd_far_model (.clk(clk), .rst(rst),
        .req_addr(req_addr), .req_serial(req_serial), .sel(sel),
        .cpu_addr(cpu_addr), .cpu_serial(cpu_serial),
        .ext_cycle(ext_cycle), .e_phase(e_phase));

    task automatic chk(input string what, input logic [15:0] seen,
        input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic flag(input string what, input logic x, input logic e);
        chk(what, {15'h0, x}, {15'h0, e});
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Straps held across the whole reset, well past the sync depth
    task automatic boot(input logic [2:0] s);
        @(posedge clk);
        rst <= 1'b1;
        straps <= s;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask

    task automatic rd_reg(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk("rdata", {8'h00, rdata}, {8'h00, e});
    endtask

    task automatic sel_at(input logic [15:0] a, input logic s,
        input mrd_pkg::mrd_sel_type e);
        @(posedge clk);
        req_addr <= a;
        req_serial <= s;
        #1;
        chk("sel", 16'(sel), 16'(e));
    endtask

    // Debug strobes: 0 serial command, 1 instruction, 2 exit
    task automatic pulse(input int k, input logic e);
        @(posedge clk);
        pv[k] <= 1'b1;
        @(posedge clk);
        pv <= 3'h0;
        @(posedge clk);
        #1;
        flag("dbg_active", dbg_act, e);
    endtask

    initial begin
        repeat (3000) @(posedge clk);
        err_total++;
        stop_test;
    end

    initial begin
        boot(3'h4);
        rd_reg(mrd_pkg::OFF_MODE, 8'h90);
        @(posedge clk);
        #1;
        chk("rdata idle", {8'h00, rdata}, 16'h0000);
        flag("dbg_active", dbg_act, 1'b0);
        flag("e_clk", e_clk, 1'b0);
        sel_at(16'h0100, 1'b0, mrd_pkg::SEL_REG);
        sel_at(16'h0200, 1'b0, mrd_pkg::SEL_RAM);
        sel_at(16'h0c00, 1'b0, mrd_pkg::SEL_EE);
        sel_at(16'h1000, 1'b0, mrd_pkg::SEL_FLASH);
        sel_at(16'h8000, 1'b0, mrd_pkg::SEL_FLASH);
        sel_at(16'h0a00, 1'b0, mrd_pkg::SEL_NONE);
        sel_at(16'hff20, 1'b0, mrd_pkg::SEL_FLASH);
        pulse(1, 1'b0);
        dbg_en <= 1'b1;
        pulse(0, 1'b1);
        sel_at(16'hff20, 1'b0, mrd_pkg::SEL_DBGROM);
        sel_at(16'hff03, 1'b0, mrd_pkg::SEL_DBGREG);
        sel_at(16'hff10, 1'b1, mrd_pkg::SEL_FLASH);
        pulse(2, 1'b0);
        pulse(1, 1'b1);
        pulse(2, 1'b0);
        wr_reg(mrd_pkg::OFF_REGPOS, 8'h08);
        sel_at(16'h0800, 1'b0, mrd_pkg::SEL_REG);
        sel_at(16'h0000, 1'b0, mrd_pkg::SEL_RAM);
        rd_reg(mrd_pkg::OFF_REGPOS, 8'h08);
        wr_reg(mrd_pkg::OFF_REGPOS, 8'h10);
        rd_reg(mrd_pkg::OFF_REGPOS, 8'h08);
        wr_reg(mrd_pkg::OFF_MODE, 8'hb4);
        rd_reg(mrd_pkg::OFF_MODE, 8'hb4);
        sel_at(16'h0a00, 1'b0, mrd_pkg::SEL_EXT);
        @(posedge clk);
        #1;
        flag("e_clk ext", e_clk, 1'b1);
        flag("vis_en", vis_en, 1'b0);
        wr_reg(mrd_pkg::OFF_REGPOS, 8'h11);
        rd_reg(mrd_pkg::OFF_REGPOS, 8'h09);
        wait_mode <= 1'b1;
        @(posedge clk);
        #1;
        flag("map_off", map_off, 1'b1);
        flag("ext_off early", ext_off, 1'b0);
        repeat (6) @(posedge clk);
        #1;
        flag("ext_off", ext_off, 1'b1);
        wait_mode <= 1'b0;
        wr_reg(mrd_pkg::OFF_MODE, 8'hf8);
        rd_reg(mrd_pkg::OFF_MODE, 8'hb0);

        // Special single chip: debug live from reset
        boot(3'h0);
        rd_reg(mrd_pkg::OFF_MODE, 8'h19);
        flag("dbg_active", dbg_act, 1'b1);
        sel_at(16'hffff, 1'b0, mrd_pkg::SEL_DBGROM);
        sel_at(16'hff00, 1'b0, mrd_pkg::SEL_DBGREG);
        sel_at(16'hff06, 1'b0, mrd_pkg::SEL_DBGREG);
        sel_at(16'hff10, 1'b0, mrd_pkg::SEL_NONE);
        flag("vis_en", vis_en, 1'b0);
        wr_reg(mrd_pkg::OFF_MODE, 8'h79);
        rd_reg(mrd_pkg::OFF_MODE, 8'h19);
        wr_reg(mrd_pkg::OFF_MODE, 8'h79);
        rd_reg(mrd_pkg::OFF_MODE, 8'h79);
        flag("vis_en", vis_en, 1'b1);
        flag("port_e_data_hidden", port_e_data_hid, 1'b1);
        wr_reg(mrd_pkg::OFF_MODE, 8'h59);
        rd_reg(mrd_pkg::OFF_MODE, 8'h79);
        wr_reg(mrd_pkg::OFF_MODE, 8'h7d);
        rd_reg(mrd_pkg::OFF_MODE, 8'h79);
        wr_reg(mrd_pkg::OFF_MODE, 8'h39);
        flag("vis_wide", vis_wide, 1'b1);
        wr_reg(mrd_pkg::OFF_MODE, 8'h29);
        rd_reg(mrd_pkg::OFF_MODE, 8'h39);
        flag("e_clk vis", e_clk, e_phase);
        wr_reg(mrd_pkg::OFF_MODE, 8'h38);
        rd_reg(mrd_pkg::OFF_MODE, 8'h38);
        flag("port_e_data_hidden", port_e_data_hid, 1'b0);
        wr_reg(mrd_pkg::OFF_REGPOS, 8'h08);
        wr_reg(mrd_pkg::OFF_REGPOS, 8'h10);
        rd_reg(mrd_pkg::OFF_REGPOS, 8'h10);
        sel_at(16'h1000, 1'b0, mrd_pkg::SEL_REG);
        wr_reg(mrd_pkg::OFF_MISC, 8'h80);
        sel_at(16'h8000, 1'b0, mrd_pkg::SEL_EXT);
        sel_at(16'h9000, 1'b0, mrd_pkg::SEL_FLASH);
        sel_at(16'h7000, 1'b0, mrd_pkg::SEL_FLASH);
        pulse(2, 1'b0);
        pulse(1, 1'b1);

        // Special peripheral and the reserved strap code
        boot(3'h2);
        rd_reg(mrd_pkg::OFF_MODE, 8'h00);
        wr_reg(mrd_pkg::OFF_MODE, 8'h79);
        rd_reg(mrd_pkg::OFF_MODE, 8'h00);
        boot(3'h6);
        rd_reg(mrd_pkg::OFF_MODE, 8'h00);
        flag("vis_en", vis_en, 1'b1);
        stop_test;
    end
endmodule
